// File: src/vpw_consts.svh
/*
 * Constants of the VPW frame and symbol codec: register offsets, field
 * positions, reset values, CRC figures and symbol times.
 * Assumes a 100 MHz sys_clk; times are in microseconds, the resync window in cycles.
 */
`ifndef VPW_CONSTS_SVH
`define VPW_CONSTS_SVH
// Register offsets
`define VPW_ADDR_DATA   4'h0
`define VPW_ADDR_CTRL   4'h4
`define VPW_ADDR_STAT   4'h8
// Control fields
`define VPW_CTRL_FAST   0
`define VPW_CTRL_SEND   1
`define VPW_CTRL_FLUSH  2
`define VPW_FAST_RESET  1'b0
// Status flag positions
`define VPW_ST_RXRDY    0
`define VPW_ST_CRCERR   1
`define VPW_ST_EOF      2
`define VPW_ST_INVAL    3
`define VPW_ST_TXDONE   4
`define VPW_ST_LOST     5
`define VPW_ST_TXERR    6
`define VPW_FLAGS_RESET 7'h00
// Frame figures
`define VPW_CRC_POLY    8'h1D
`define VPW_CRC_INIT    8'hFF
`define VPW_CRC_GOOD    8'hC4
`define VPW_MAX_BYTES   4'hC
`define VPW_MAX_DATA    4'hB
// Timing at 10.4 kbps: clock in MHz, times in microseconds, resync window in cycles
`define VPW_CLK_MHZ     100
`define VPW_SHORT_US    64
`define VPW_LONG_US     128
`define VPW_SOF_US      200
`define VPW_EOF_US      280
`define VPW_IFS_US      300
`define VPW_BRK_US      240
`define VPW_SPLIT_B_US  96
`define VPW_SPLIT_S_US  164
`define VPW_MIN_US      34
`define VPW_GUARD_US    20
`define VPW_RESYNC_CYC  104
`endif

// File: src/vpw_pkg.sv
/*
 * Types shared by the VPW codec modules.
 * Assumes vpw_consts.svh supplies the numeric constants.
 */
package vpw_pkg;
	typedef logic [7:0] vpw_byte_t;
	typedef enum logic [1:0] {
		TX_WAIT = 2'b00,
		TX_SOF  = 2'b01,
		TX_BITS = 2'b10
	} vpw_tx_e;
endpackage : vpw_pkg

// File: src/vpw_crc_if.sv
/*
 * Carrier between the codec and a serial CRC engine.
 * Assumes one user and one engine on the same sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
interface vpw_crc_if;
	import vpw_pkg::*;
	logic      init;  // Preset remainder
	logic      shift; // Shift one bit in
	logic      din;   // Bit, MSB first
	vpw_byte_t rem;   // Current remainder
	modport user   (output init, output shift, output din, input rem);
	modport engine (input init, input shift, input din, output rem);
endinterface : vpw_crc_if
`default_nettype wire

// File: src/vpw_crc8.sv
/*
 * Serial CRC-8 engine, one bit per shift, MSB first.
 * Assumes init and shift come from logic on the same sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "vpw_consts.svh"
module vpw_crc8
	import vpw_pkg::*;
(
	input wire logic   sys_clk,
	input wire logic   rstn,
	vpw_crc_if.engine  crc
);
	vpw_byte_t rem_reg;
	vpw_byte_t rem_next;
	logic      fb;

	// Feedback and polynomial step
	assign fb       = rem_reg[7] ^ crc.din;
	assign rem_next = {rem_reg[6:0], 1'b0} ^ (fb ? `VPW_CRC_POLY : 8'h00); // [RQ4]
	assign crc.rem  = rem_reg;

	// Remainder register, preset to all ones
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rem_reg <= `VPW_CRC_INIT;
		end else if (crc.init) begin
			rem_reg <= `VPW_CRC_INIT; // [RQ4]
		end else if (crc.shift) begin
			rem_reg <= rem_next;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	crc_preset_a: assert property (crc.init |=> rem_reg == 8'hFF) // [RQ4]
		else $error("crc not preset");
	crc_step_a: assert property (!crc.init && crc.shift && !fb |=>
		rem_reg == {$past(rem_reg[6:0]), 1'b0}) // [RQ4]
		else $error("crc shift wrong");
endmodule : vpw_crc8
`default_nettype wire

// File: src/vpw_frame_symbol_codec.sv
/*
 * VPW frame and symbol codec: encodes and decodes bits and symbols,
 * frames transmit messages with CRC, checks received frames, handles
 * separation-period resync and break. Registers on a plain port.
 * Assumes an off-chip transceiver: bus_tx_active high drives the bus
 * active, filtered_rx_input high means the bus is active.
 */
// Operation
// [RQ1] Messages hold at most twelve bytes, each sent MSB first.
// [RQ2] Every sent message starts with a 200 us active start symbol, outside CRC.
// [RQ3] A message holds at least one data byte plus the check byte.
// [RQ4] CRC polynomial x8+x4+x3+x2+1, preset ones, bytes shifted serially.
// [RQ5] Sent check byte is the inverted final remainder, MSB first.
// [RQ6] Receive CRC covers all bytes with check; remainder not C4 flags error.
// [RQ7] End of data is 200 us passive after a falling edge; no flag.
// [RQ8] Passive reaching 280 us is end of frame; its flag is set.
// [RQ9] Nodes wait 300 us of passive bus before a new start symbol.
// [RQ10] Rising edge in separation resyncs; writes within 104 cycles transmit.
// [RQ11] Receiver accepts a start symbol beginning in the separation period.
// [RQ12] The device can never generate a break symbol.
// [RQ13] Break seen while sending is a transmit error; sending stops at once.
// [RQ14] Break while receiving flags invalid, drops frame, clears fast receive.
// [RQ15] Passive beyond 300 us is idle; a pending message may start.
// [RQ16] Each bit has one transition; levels alternate; 64 or 128 us.
// [RQ17] Logic zero is 64 us passive or 128 us active.
// [RQ18] Logic one is 128 us passive or 64 us active.
// [RQ19] First bit of every byte is passive since the start is active.
// [RQ20] Break is an active period of at least 240 us.
// [RQ21] All nominal times follow a 10.4 kbps bus rate.
// [RQ22] Normalization bits use data bit timing, only in responses.
// [RQ23] A zero of either level dominates a simultaneous one.
// [RQ24] Sending recessive but seeing dominant loses arbitration; stop at once.
// [RQ25] All durations are counted in interface clock periods.
`timescale 1ns/1ns
`default_nettype none
`include "vpw_consts.svh"
module vpw_frame_symbol_codec
	import vpw_pkg::*;
#(
	parameter int T_SHORT   = `VPW_SHORT_US   * `VPW_CLK_MHZ,
	parameter int T_LONG    = `VPW_LONG_US    * `VPW_CLK_MHZ,
	parameter int T_SOF     = `VPW_SOF_US     * `VPW_CLK_MHZ,
	parameter int T_EOF     = `VPW_EOF_US     * `VPW_CLK_MHZ,
	parameter int T_IFS     = `VPW_IFS_US     * `VPW_CLK_MHZ,
	parameter int T_BRK     = `VPW_BRK_US     * `VPW_CLK_MHZ,
	parameter int T_SPLIT_B = `VPW_SPLIT_B_US * `VPW_CLK_MHZ,
	parameter int T_SPLIT_S = `VPW_SPLIT_S_US * `VPW_CLK_MHZ,
	parameter int T_MIN     = `VPW_MIN_US     * `VPW_CLK_MHZ,
	parameter int T_GUARD   = `VPW_GUARD_US   * `VPW_CLK_MHZ
)
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        filtered_rx_input,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             bus_tx_active,
	output logic             fast_receive_mode
);
	// Cycle counts from the nominal times [RQ21] [RQ25]
	localparam logic [15:0] C_SHORT   = 16'(T_SHORT);
	localparam logic [15:0] C_LONG    = 16'(T_LONG);
	localparam logic [15:0] C_SOF     = 16'(T_SOF);
	localparam logic [15:0] C_EOF     = 16'(T_EOF);
	localparam logic [15:0] C_IFS     = 16'(T_IFS);
	localparam logic [15:0] C_BRK     = 16'(T_BRK);
	localparam logic [15:0] C_SPLIT_B = 16'(T_SPLIT_B);
	localparam logic [15:0] C_SPLIT_S = 16'(T_SPLIT_S);
	localparam logic [15:0] C_MIN     = 16'(T_MIN);
	localparam logic [15:0] C_GUARD   = 16'(T_GUARD);
	localparam logic [7:0]  C_RESYNC  = 8'(`VPW_RESYNC_CYC);

	logic        s1_reg, s2_reg, s3_reg;
	logic        lvl_reg, lvl_next;
	logic [15:0] dur_reg, dur_next;
	logic        edge_seen, rise, fall, too_short;
	logic        fall_bit, rise_bit, fall_sof, bit_evt, bit_val;
	logic        brk_evt, eod_evt, eof_evt, bus_idle, ifs_win;
	logic        rx_infr_reg, rx_infr_next;
	logic [7:0]  rx_sh_reg, rx_data_reg;
	logic [2:0]  rx_bit_reg;
	logic [3:0]  rx_cnt_reg;
	logic        byte_done, rx_ovf, rx_bad;
	logic [6:0]  flags_reg, flags_next, flag_set, flag_clr;
	logic        fast_reg;
	vpw_byte_t   tx_mem [0:10];
	logic [3:0]  tx_n_reg;
	logic        pend_reg;
	logic [7:0]  sync_cnt_reg;
	logic        sync_run_reg;
	vpw_tx_e     tx_st_reg, tx_st_next;
	logic [15:0] tx_cnt_reg, tx_cnt_next, elem_len;
	logic        tx_lvl_reg, tx_lvl_next;
	logic [3:0]  tx_bidx_reg, tx_bidx_next;
	logic [2:0]  tx_bit_reg, tx_bit_next;
	vpw_byte_t   mem_byte, cur_byte;
	logic        cur_bit, elem_end, last_bit, mismatch, brk_tx, tx_stop;
	logic        start_idle, start_sync, tx_start, tx_done, tx_shift;
	logic        wr_data, wr_ctrl, wr_stat, sel_data, sel_ctrl, sel_stat;
	logic [31:0] rd_mux;
	vpw_crc_if   rx_crc ();
	vpw_crc_if   tx_crc ();

	// Pin synchroniser: three stages, change taken when two and three agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= filtered_rx_input;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Bus level and time since the last transition [RQ25]
	assign lvl_next  = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
	assign edge_seen = lvl_next ^ lvl_reg;
	assign rise      = edge_seen & lvl_next;
	assign fall      = edge_seen & ~lvl_next;
	assign dur_next  = edge_seen ? 16'h0000 :
		(dur_reg == 16'hFFFF) ? dur_reg : dur_reg + 16'h0001;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lvl_reg <= 1'b0;
			dur_reg <= 16'h0000;
		end else begin
			lvl_reg <= lvl_next;
			dur_reg <= dur_next;
		end
	end

	// Symbol decode on each transition and on passive or active timeouts
	assign too_short = dur_reg < C_MIN;
	assign fall_bit  = fall & ~too_short & (dur_reg < C_SPLIT_S);      // [RQ16]
	assign rise_bit  = rise & ~too_short & (dur_reg < C_SPLIT_S);      // [RQ16]
	assign fall_sof  = fall & (dur_reg >= C_SPLIT_S) & (dur_reg < C_BRK); // [RQ11]
	// Active short is one, passive short is zero; normalization bits alike
	assign bit_val   = fall ? (dur_reg < C_SPLIT_B)                    // [RQ18]
		: (dur_reg >= C_SPLIT_B);                                        // [RQ17] [RQ22]
	assign bit_evt   = rx_infr_reg & (fall_bit | rise_bit);
	assign brk_evt   = lvl_reg & ~edge_seen & (dur_reg == C_BRK);       // [RQ20]
	assign eod_evt   = ~lvl_reg & ~edge_seen & (dur_reg == C_SPLIT_S);  // [RQ7]
	assign eof_evt   = ~lvl_reg & ~edge_seen & (dur_reg == C_EOF);      // [RQ8]
	assign ifs_win   = ~lvl_reg & (dur_reg >= C_EOF) & (dur_reg < C_IFS);
	assign bus_idle  = ~lvl_reg & (dur_reg >= C_IFS);                   // [RQ15]

	// Receive framing: byte assembly, byte limit, frame drop
	assign byte_done = bit_evt & (rx_bit_reg == 3'h7);
	assign rx_ovf    = byte_done & (rx_cnt_reg == `VPW_MAX_BYTES);      // [RQ1]
	assign rx_bad    = rx_infr_reg & ((edge_seen & too_short) | brk_evt | rx_ovf
		| (eod_evt & (rx_bit_reg != 3'h0)));
	assign rx_infr_next = fall_sof ? 1'b1 : (rx_bad | eod_evt) ? 1'b0 : rx_infr_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_infr_reg <= 1'b0;
			rx_sh_reg   <= 8'h00;
			rx_bit_reg  <= 3'h0;
			rx_cnt_reg  <= 4'h0;
			rx_data_reg <= 8'h00;
		end else begin
			rx_infr_reg <= rx_infr_next; // [RQ14]
			if (fall_sof) begin
				rx_bit_reg <= 3'h0;
				rx_cnt_reg <= 4'h0;
			end else if (bit_evt) begin
				rx_sh_reg  <= {rx_sh_reg[6:0], bit_val}; // [RQ1]
				rx_bit_reg <= rx_bit_reg + 3'h1;
				if (byte_done) begin
					rx_data_reg <= {rx_sh_reg[6:0], bit_val};
					rx_cnt_reg  <= rx_cnt_reg + 4'h1;
				end
			end
		end
	end

	// Receive CRC: start symbol excluded, check byte included
	assign rx_crc.init  = fall_sof;
	assign rx_crc.shift = bit_evt;                                     // [RQ6]
	assign rx_crc.din   = bit_val;
	vpw_crc8 u_rx_crc (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.crc     (rx_crc.engine)
	);

	// Register decode
	assign sel_data = reg_addr == `VPW_ADDR_DATA;
	assign sel_ctrl = reg_addr == `VPW_ADDR_CTRL;
	assign sel_stat = reg_addr == `VPW_ADDR_STAT;
	assign wr_data  = reg_wr & sel_data & (tx_st_reg == TX_WAIT) & ~pend_reg
		& (tx_n_reg < `VPW_MAX_DATA);                                    // [RQ1]
	assign wr_ctrl  = reg_wr & sel_ctrl;
	assign wr_stat  = reg_wr & sel_stat;
	assign rd_mux   = sel_data ? {24'h000000, rx_data_reg} :
		sel_ctrl ? {29'h00000000, 1'b0, pend_reg, fast_reg} :
		sel_stat ? {22'h000000, tx_st_reg != TX_WAIT, bus_idle, 1'b0, flags_reg} :
		32'h00000000;

	// Sticky flags: hardware set wins over a write-one clear
	always_comb begin
		flag_set                 = 7'h00;
		flag_set[`VPW_ST_RXRDY]  = byte_done & ~rx_ovf;
		flag_set[`VPW_ST_CRCERR] = eod_evt & rx_infr_reg & (rx_bit_reg == 3'h0)
			& (rx_crc.rem != `VPW_CRC_GOOD);                              // [RQ6]
		flag_set[`VPW_ST_EOF]    = eof_evt;                             // [RQ8]
		flag_set[`VPW_ST_INVAL]  = rx_bad;                              // [RQ14]
		flag_set[`VPW_ST_TXDONE] = tx_done;
		flag_set[`VPW_ST_LOST]   = mismatch;
		flag_set[`VPW_ST_TXERR]  = brk_tx;                              // [RQ13]
	end
	assign flag_clr   = wr_stat ? reg_wdata[6:0] : 7'h00;
	assign flags_next = (flags_reg & ~flag_clr) | flag_set;

	// Register file and read port, data one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= `VPW_FLAGS_RESET;
			fast_reg  <= `VPW_FAST_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			flags_reg <= flags_next;
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
			if (brk_evt & rx_infr_reg) begin
				fast_reg <= 1'b0; // [RQ14]
			end else if (wr_ctrl) begin
				fast_reg <= reg_wdata[`VPW_CTRL_FAST];
			end
		end
	end

	// Transmit buffer and send request
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_n_reg <= 4'h0;
			pend_reg <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_n_reg <= tx_n_reg + 4'h1;
			end else if (tx_done | (wr_ctrl & reg_wdata[`VPW_CTRL_FLUSH]
				& (tx_st_reg == TX_WAIT))) begin
				tx_n_reg <= 4'h0;
			end
			if (tx_done | tx_stop | (wr_ctrl & reg_wdata[`VPW_CTRL_FLUSH])) begin
				pend_reg <= 1'b0;
			end else if (wr_ctrl & reg_wdata[`VPW_CTRL_SEND] & (tx_n_reg != 4'h0)) begin
				pend_reg <= 1'b1; // [RQ3]
			end
		end
	end

	// Buffer storage
	always_ff @(posedge sys_clk) begin
		if (wr_data) begin
			tx_mem[tx_n_reg] <= reg_wdata[7:0];
		end
	end

	// Resync window: 104 cycles from a rising edge in the separation period
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync_run_reg <= 1'b0;
			sync_cnt_reg <= 8'h00;
		end else if (rise & ifs_win) begin
			sync_run_reg <= 1'b1; // [RQ10]
			sync_cnt_reg <= 8'h00;
		end else if (sync_run_reg) begin
			sync_cnt_reg <= sync_cnt_reg + 8'h01;
			sync_run_reg <= sync_cnt_reg < (C_RESYNC - 8'h02);
		end
	end

	// Start on an idle bus, or join a start symbol seen in the window
	assign start_idle = pend_reg & bus_idle & ~edge_seen;                // [RQ9] [RQ15]
	assign start_sync = pend_reg & sync_run_reg;                         // [RQ10]
	assign tx_start   = (tx_st_reg == TX_WAIT) & (start_idle | start_sync);

	// Element currently sent: start symbol or data and check bits
	assign mem_byte = (tx_bidx_reg < `VPW_MAX_DATA) ? tx_mem[tx_bidx_reg] : 8'h00;
	assign cur_byte = (tx_bidx_reg == tx_n_reg) ? ~tx_crc.rem : mem_byte; // [RQ5]
	assign cur_bit  = cur_byte[~tx_bit_reg];                            // [RQ1]
	assign elem_len = (tx_st_reg == TX_SOF) ? C_SOF :                   // [RQ2]
		tx_lvl_reg ? (cur_bit ? C_SHORT : C_LONG) :                      // [RQ17]
		(cur_bit ? C_LONG : C_SHORT);                                    // [RQ18]
	assign elem_end = tx_cnt_reg >= (elem_len - 16'h0001); // A late resync preload still ends
	assign last_bit = (tx_bidx_reg == tx_n_reg) & (tx_bit_reg == 3'h7);

	// Loss when the bus shows the other level once past the filter delay
	assign mismatch = (tx_st_reg != TX_WAIT) & (tx_cnt_reg >= C_GUARD)
		& (lvl_reg != tx_lvl_reg) & ~brk_evt;                            // [RQ23] [RQ24]
	assign brk_tx   = (tx_st_reg != TX_WAIT) & brk_evt;                // [RQ13]
	assign tx_stop  = mismatch | brk_tx;
	assign tx_shift = (tx_st_reg == TX_BITS) & elem_end & ~tx_stop
		& (tx_bidx_reg != tx_n_reg);                                     // [RQ4]
	assign tx_done  = (tx_st_reg == TX_BITS) & elem_end & ~tx_stop & last_bit;

	// Transmit sequencer next state
	always_comb begin
		tx_st_next   = tx_st_reg;
		tx_cnt_next  = tx_cnt_reg + 16'h0001;
		tx_lvl_next  = tx_lvl_reg;
		tx_bidx_next = tx_bidx_reg;
		tx_bit_next  = tx_bit_reg;
		case (tx_st_reg)
			TX_WAIT: begin
				tx_cnt_next = 16'h0000;
				tx_lvl_next = 1'b0;
				if (tx_start) begin
					tx_st_next   = TX_SOF;
					tx_lvl_next  = 1'b1; // [RQ2]
					tx_cnt_next  = start_sync ? {8'h00, sync_cnt_reg + 8'h01} : 16'h0000;
					tx_bidx_next = 4'h0;
					tx_bit_next  = 3'h0;
				end
			end
			TX_SOF: begin
				if (tx_stop) begin
					tx_st_next  = TX_WAIT;
					tx_lvl_next = 1'b0;
				end else if (elem_end) begin
					tx_st_next  = TX_BITS;
					tx_lvl_next = 1'b0; // [RQ19]
					tx_cnt_next = 16'h0000;
				end
			end
			TX_BITS: begin
				if (tx_stop | (elem_end & last_bit)) begin
					tx_st_next  = TX_WAIT;
					tx_lvl_next = 1'b0;
				end else if (elem_end) begin
					tx_lvl_next = ~tx_lvl_reg; // [RQ16]
					tx_cnt_next = 16'h0000;
					tx_bit_next = tx_bit_reg + 3'h1;
					if (tx_bit_reg == 3'h7) begin
						tx_bidx_next = tx_bidx_reg + 4'h1;
					end
				end
			end
			default: begin
				tx_st_next  = TX_WAIT;
				tx_lvl_next = 1'b0;
			end
		endcase
	end

	// Transmit sequencer registers; bus drive comes straight from a flop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_st_reg   <= TX_WAIT;
			tx_cnt_reg  <= 16'h0000;
			tx_lvl_reg  <= 1'b0;
			tx_bidx_reg <= 4'h0;
			tx_bit_reg  <= 3'h0;
		end else begin
			tx_st_reg   <= tx_st_next;
			tx_cnt_reg  <= tx_cnt_next;
			tx_lvl_reg  <= tx_lvl_next;
			tx_bidx_reg <= tx_bidx_next;
			tx_bit_reg  <= tx_bit_next;
		end
	end
	assign bus_tx_active     = tx_lvl_reg;
	assign fast_receive_mode = fast_reg;

	// Transmit CRC over data bytes only, preset at the start symbol
	assign tx_crc.init  = tx_start;
	assign tx_crc.shift = tx_shift;
	assign tx_crc.din   = cur_bit;
	vpw_crc8 u_tx_crc (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.crc     (tx_crc.engine)
	);

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	logic [15:0] act_run_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			act_run_reg <= 16'h0000;
		end else begin
			act_run_reg <= tx_lvl_reg ? act_run_reg + 16'h0001 : 16'h0000;
		end
	end

	sequence s_edge_pend;
		rise && ifs_win && tx_st_reg == TX_WAIT;
	endsequence
	sequence s_join;
		pend_reg && sync_run_reg && tx_st_reg == TX_WAIT;
	endsequence

	no_break_tx_a: assert property (act_run_reg <= C_SOF) // [RQ12]
		else $error("active drive longer than start symbol");
	sof_start_a: assert property (tx_st_reg == TX_WAIT && tx_start
		|=> tx_lvl_reg && tx_st_reg == TX_SOF) // [RQ2]
		else $error("start symbol not driven active");
	min_bytes_a: assert property (tx_start |-> tx_n_reg != 4'h0) // [RQ3]
		else $error("message started without data");
	first_passive_a: assert property (tx_st_reg == TX_SOF && tx_st_next == TX_BITS
		|=> !tx_lvl_reg && $fell(tx_lvl_reg)) // [RQ19]
		else $error("first bit not passive");
	crc_flag_a: assert property (flag_set[`VPW_ST_CRCERR]
		|=> flags_reg[`VPW_ST_CRCERR]) // [RQ6]
		else $error("crc error flag lost");
	eof_flag_a: assert property (!lvl_reg && dur_reg == C_EOF && !edge_seen
		|=> flags_reg[`VPW_ST_EOF]) // [RQ8]
		else $error("end of frame flag not set");
	eod_quiet_a: assert property (eod_evt && !rx_bad |=> !$rose(flags_reg[`VPW_ST_INVAL])) // [RQ7]
		else $error("flag raised on end of data");
	rx_break_a: assert property (brk_evt && rx_infr_reg
		|=> flags_reg[`VPW_ST_INVAL] && !fast_reg && !rx_infr_reg) // [RQ14]
		else $error("receive break not handled");
	tx_break_a: assert property (brk_tx
		|=> tx_st_reg == TX_WAIT && !tx_lvl_reg && flags_reg[`VPW_ST_TXERR]) // [RQ13]
		else $error("transmit break not handled");
	lost_arb_a: assert property (mismatch
		|=> !tx_lvl_reg && tx_st_reg == TX_WAIT && flags_reg[`VPW_ST_LOST]) // [RQ24]
		else $error("arbitration loss not handled");
	resync_join_a: assert property (s_edge_pend ##1 s_join |=> tx_st_reg == TX_SOF) // [RQ10]
		else $error("write in resync window not sent");
	idle_only_a: assert property (tx_start && !start_sync |-> bus_idle) // [RQ15]
		else $error("start on a busy bus");
endmodule : vpw_frame_symbol_codec
`default_nettype wire

// File: bench/vpw_node_model.sv
/*
 * Behavioural far-side bus node for the VPW codec bench.
 * Assumes the bench ORs this drive with the device's drive onto the bus.
 */
`timescale 1ns/1ns
`default_nettype none
module vpw_node_model #(
	parameter int TS   = 8,
	parameter int TL   = 16,
	parameter int TSOF = 24
) (
	input  wire logic sys_clk,
	output var  logic drv
);
	initial drv = 1'b0;
	// One element held at a level for n cycles
	task automatic elem(input logic lvl, input int n);
		drv <= lvl;
		repeat (n) @(posedge sys_clk);
	endtask : elem
	// Start symbol, two bytes MSB first from a passive bit, then release
	task automatic frame(input logic [15:0] w);
		elem(1'b1, TSOF);
		for (int i = 0; i < 16; i++) begin
			elem(i[0], (i[0] ^ w[15-i]) ? TL : TS);
		end
		drv <= 1'b0;
	endtask : frame
	// Start symbol and one bit, then an active period of n cycles
	task automatic brk(input int n);
		elem(1'b1, TSOF);
		elem(1'b0, TS);
		elem(1'b1, n);
		drv <= 1'b0;
	endtask : brk
endmodule : vpw_node_model
`default_nettype wire

// File: bench/testbench.sv
/*
 * Self-checking bench for the VPW frame and symbol codec.
 * Assumes the codec built with short counts and one far-side node model.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import vpw_pkg::*;
	localparam int TS = 8;
	localparam int TL = 16;
	localparam int TSOF = 24;
	localparam int TEOF = 35;
	localparam int TIFS = 38;
	localparam int TBRK = 30;
	localparam int TSPB = 12;
	localparam int TSPS = 20;
	localparam int TMIN = 4;
	localparam int TGRD = 5; // Beyond the four-cycle input sync delay
	typedef struct packed {logic [3:0] a; logic [31:0] w; logic [31:0] e;} vpw_row_s;
	logic        sys_clk, rstn, rx, reg_wr, reg_rd, bus_tx_active, fast_receive_mode, drv, rec;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [15:0] w;
	int          fails, checked, run;
	int          runs[$];
	vpw_row_s    rows[5] = '{'{4'h4, 32'h1, 32'h1}, '{4'h4, 32'h0, 32'h0},
		'{4'hC, 32'hFF, 32'h0}, '{4'h8, 32'h7F, 32'h100}, '{4'h4, 32'h4, 32'h0}};
	// Wired bus: either party drives it active
	assign rx = bus_tx_active | drv;
	vpw_frame_symbol_codec #(.T_SHORT(TS), .T_LONG(TL), .T_SOF(TSOF), .T_EOF(TEOF), .T_IFS(TIFS),
		.T_BRK(TBRK), .T_SPLIT_B(TSPB), .T_SPLIT_S(TSPS), .T_MIN(TMIN), .T_GUARD(TGRD))
	i_vpw_frame_symbol_codec (.sys_clk(sys_clk), .rstn(rstn), .filtered_rx_input(rx),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus_tx_active(bus_tx_active),
		.fast_receive_mode(fast_receive_mode));
	vpw_node_model #(.TS(TS), .TL(TL), .TSOF(TSOF)) i_vpw_node_model (.sys_clk(sys_clk), .drv(drv));
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Run lengths of the device's own drive
	always @(posedge sys_clk) begin
		if (rec && (bus_tx_active !== ((runs.size() % 2) == 1))) begin
			runs.push_back(run);
			run = 1;
		end else if (rec) begin
			run++;
		end
	end
	function automatic logic [7:0] crc_of(input logic [7:0] d);
		logic [7:0] r;
		r = 8'hFF;
		for (int i = 7; i >= 0; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h1D : 8'h00);
		end
		return ~r;
	endfunction : crc_of
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd
	// Poll status until a flag shows, bounded
	task automatic wait_st(input int b);
		for (int n = 0; n < 400; n++) begin
			rd(4'h8);
			if (rv[b] === 1'b1) break;
		end
	endtask : wait_st
	task automatic tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		{rstn, reg_wr, reg_rd, rec, reg_addr, reg_wdata, run} = '0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk({reg_rdata[29:0], bus_tx_active, fast_receive_mode}, 32'h0);
		repeat (50) @(posedge sys_clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk(rv, rows[i].e);
		end
		// Transmit one data byte and its check byte
		w = {8'hA5, crc_of(8'hA5)};
		wr(4'h0, 32'hA5);
		rec <= 1'b1;
		wr(4'h4, 32'h2);
		wait_st(4);
		chk(rv & 32'h10, 32'h10);
		rec <= 1'b0;
		chk(32'(runs.size()), 32'd18);
		chk(32'(runs[1]), 32'(TSOF));
		for (int i = 0; i < 16; i++) begin
			chk(32'(runs[2+i]), 32'((i[0] ^ w[15-i]) ? TL : TS));
		end
		repeat (80) @(posedge sys_clk);
		wr(4'h8, 32'h7F);
		// Good frame from the far side
		i_vpw_node_model.frame({8'h3C, crc_of(8'h3C)});
		wait_st(2);
		chk(rv & 32'h0E, 32'h04);
		repeat (60) @(posedge sys_clk);
		wr(4'h8, 32'h7F);
		// Corrupted check byte
		i_vpw_node_model.frame({8'h3C, crc_of(8'h3C) ^ 8'h01});
		wait_st(2);
		chk(rv & 32'h02, 32'h02);
		repeat (60) @(posedge sys_clk);
		wr(4'h8, 32'h7F);
		// Break in mid-reception with fast receive on
		wr(4'h4, 32'h1);
		i_vpw_node_model.brk(40);
		repeat (10) @(posedge sys_clk);
		rd(4'h8);
		chk(rv & 32'h08, 32'h08);
		chk({31'h0, fast_receive_mode}, 32'h0);
		// Pending send joins a start symbol that rises inside the separation period
		wr(4'h8, 32'h7F);
		fork
			i_vpw_node_model.frame({8'h3C, crc_of(8'h3C)});
			begin
				repeat (30) @(posedge sys_clk);
				wr(4'h0, 32'h5A);
				wr(4'h4, 32'h2);
			end
		join
		repeat (37) @(posedge sys_clk);
		i_vpw_node_model.elem(1'b1, TSOF);
		chk({31'h0, bus_tx_active}, 32'h1);
		i_vpw_node_model.elem(1'b0, 1);
		wait_st(4);
		chk(rv & 32'h30, 32'h10);
		// Reset in mid-run returns the control state to its idle values
		wr(4'h4, 32'h1);
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk({30'h0, bus_tx_active, fast_receive_mode}, 32'h0);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
